//--- rtl/serial_port_shift_engine_regs.vh
// Offsets, field positions, reset values and timing for the serial engine
`ifndef SERIAL_PORT_SHIFT_ENGINE_REGS_VH
`define SERIAL_PORT_SHIFT_ENGINE_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_SERIAL_BUFFER   2'h0
`define OFS_SERIAL_CONTROL  2'h1
`define OFS_BAUD_CONTROL    2'h2

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_MODE_HI         7
`define CTL_MODE_LO         6
`define CTL_MULTIPROC       5
`define CTL_RX_ENABLE       4
`define CTL_TX_NINTH        3
`define CTL_RX_NINTH        2
`define CTL_TX_DONE         1
`define CTL_RX_DONE         0
`define BAUD_DOUBLE         0

`define CTL_RESET           8'h00
`define BUF_RESET           8'h00
`define BAUD_RESET          8'h00

// ----------------------------------------------------------------------
// Machine cycle timing: six states of two phases each
// ----------------------------------------------------------------------
`define PHASES_PER_CYCLE    4'd12
`define PH_S1P1             4'd0
`define PH_S3P1             4'd4
`define PH_S5P2             4'd9
`define PH_S6P1             4'd10
`define PH_S6P2             4'd11

// ----------------------------------------------------------------------
// Oversampling: 7th, 8th, 9th of sixteen counter states
// ----------------------------------------------------------------------
`define VOTE_FIRST          4'd6
`define VOTE_MID            4'd7
`define VOTE_LAST           4'd8
`define DIV16_LAST          4'd15
`define RX0_PRELOAD         8'hfe
`define RX_PRELOAD          9'h1ff

`endif

//--- rtl/serial_port_shift_engine.v
// Serial port shift engine: mode 0 shift register, modes 1-3 async frames
//
// Functional notes
// - Mode 0: 8 bits LSB first, clock out
// - Buffer write loads marker, send one cycle later
// - Shift clock low S3-S5, shift at S6P2
// - Zero fill, marker ends send at S1P1
// - Receive starts on enable with done clear
// - Clock toggles S3P1/S6P1, sample at S5P2
// - Preload zero leftmost ends receive, sets flag
// - Mode 1: start, 8 data, stop to ninth
// - Async send starts after divide-by-16 rollover
// - Start bit, then data, then shifting
// - Mode 1 send ends at tenth rollover
// - Falling edge resets counter, preloads all ones
// - Majority of samples 7, 8, 9
// - False start bit resets the receiver
// - Mode 1 load only if flag clear and, with multiproc set, stop high
// - Failed load discards frame, hunt resumes
// - Modes 2/3: programmable ninth bit frame
// - Mode 2 fixed rate, mode 3 timer rate
// - Ninth bit loaded, stop inserted, eleven rollovers
// - Modes 2/3 nine-bit receive register
// - Load gated by flag, and by ninth bit with multiproc set
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps

module serial_port_shift_engine (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire [1:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       baud_tick_i,
  input  wire       rxd_i,
  output wire       rxd_o,
  output wire       rxd_oe_o,
  output wire       txd_o
);

`include "serial_port_shift_engine_regs.vh"

  localparam T_IDLE  = 4'b0001;
  localparam T_REQ   = 4'b0010;
  localparam T_START = 4'b0100;
  localparam T_DATA  = 4'b1000;

  localparam R_IDLE  = 4'b0001;
  localparam R_BIT   = 4'b0010;
  localparam R_STOP  = 4'b0100;
  localparam R_M0    = 4'b1000;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [3:0] phase;
  reg  [7:0] serial_buffer;
  reg  [1:0] mode;
  reg        multiproc_enable;
  reg        rx_enable;
  reg        transmit_ninth_bit;
  reg        received_ninth_bit;
  reg        tx_done_flag;
  reg        rx_done_flag;
  reg        double_rate;
  reg  [1:0] pre;
  reg        half;
  reg        s16_tick;
  reg  [3:0] tx_div;
  reg  [3:0] tx_st;
  reg  [9:0] tx_sr;
  reg        tx_end;
  reg  [3:0] rx_st;
  reg  [3:0] rx_div;
  reg  [8:0] rx_sr;
  reg  [2:0] votes;
  reg        rx_prev;
  reg        rx_first;
  reg        rx0_arm;
  reg        rx0_end;
  reg        rx0_pin;
  reg        tx_set;
  reg        rx_set;
  reg        rx_load;
  reg  [7:0] rx_byte;
  reg        rx_ninth;
  wire       wr_buf;
  wire       wr_ctl;
  wire       mode0;
  wire       tx_roll;
  wire       rx_roll;
  wire       vote;
  wire       sclk_on;
  wire       load_ok;

  assign wr_buf  = wr_i & (addr_i == `OFS_SERIAL_BUFFER);
  assign wr_ctl  = wr_i & (addr_i == `OFS_SERIAL_CONTROL);
  assign mode0   = (mode == 2'd0);
  assign tx_roll = s16_tick & (tx_div == `DIV16_LAST);
  assign rx_roll = s16_tick & (rx_div == `DIV16_LAST);
  // Two of three wins, so one noisy sample is absorbed
  assign vote    = (votes[0] & votes[1]) | (votes[1] & votes[2]) |
                   (votes[0] & votes[2]);

  // Bit reversal: shift-left capture puts the first bit on top
  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      rev8 = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        rev8[i] = v[7-i];
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Machine cycle phase counter, S1P1 .. S6P2
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= `PH_S1P1;
    end else if (phase == `PH_S6P2) begin
      phase <= `PH_S1P1;
    end else begin
      phase <= phase + 4'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Sixteen-times bit rate tick
  // ----------------------------------------------------------------------
  // Mode 2 divides the core clock; modes 1 and 3 follow the timer tick,
  // halved unless the doubling bit is set
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre      <= 2'd0;
      half     <= 1'b0;
      s16_tick <= 1'b0;
    end else begin
      pre      <= pre + 2'd1;
      s16_tick <= 1'b0;
      if (mode == 2'd2) begin
        s16_tick <= double_rate ? pre[0] : (pre == 2'd3);
      end else if (baud_tick_i) begin
        half     <= ~half;
        s16_tick <= double_rate | half;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit divide-by-16 counter, free running
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_div <= 4'd0;
    end else if (s16_tick) begin
      tx_div <= tx_div + 4'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  // The shift register holds a marker one left of the last bit; when
  // only the marker remains to the left, one final shift ends the send.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st    <= T_IDLE;
      tx_sr    <= 10'h3ff;
      tx_end   <= 1'b0;
      tx_set   <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (wr_buf) begin
        tx_st  <= T_REQ;
        tx_end <= 1'b0;
        if (mode0 || mode == 2'd1) begin
          tx_sr <= {2'b01, wdata_i};
        end else begin
          tx_sr <= {1'b1, transmit_ninth_bit, wdata_i};
        end
      end else begin
        case (tx_st)
          T_REQ: begin
            if (mode0 && phase == `PH_S6P2) begin
              tx_st <= T_START;
            end else if (!mode0 && tx_roll) begin
              tx_st <= T_START;
            end
          end
          T_START: begin
            if (mode0 && phase == `PH_S6P2) begin
              tx_st <= T_DATA;
            end else if (!mode0 && tx_roll) begin
              tx_st <= T_DATA;
            end
          end
          T_DATA: begin
            if (mode0) begin
              if (tx_end && phase == `PH_S1P1) begin
                tx_st  <= T_IDLE;
                tx_end <= 1'b0;
                tx_set <= 1'b1;
              end else if (!tx_end && phase == `PH_S6P2) begin
                tx_sr  <= {1'b0, tx_sr[9:1]};
                tx_end <= (tx_sr[9:2] == 8'h00);
              end
            end else if (tx_roll) begin
              // Data phase opened one bit time ago: shift now
              tx_sr <= {1'b0, tx_sr[9:1]};
              if (tx_sr[9:2] == 8'h00) begin
                tx_st  <= T_IDLE;
                tx_set <= 1'b1;
              end
            end
          end
          default: begin
            tx_st <= T_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  // Mode 0 sends and receives through the data pin; the async modes
  // hunt for a falling edge at sixteen times the bit rate.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st    <= R_IDLE;
      rx_div   <= 4'd0;
      rx_sr    <= `RX_PRELOAD;
      votes    <= 3'b111;
      rx_prev  <= 1'b1;
      rx_first <= 1'b0;
      rx0_arm  <= 1'b0;
      rx0_end  <= 1'b0;
      rx0_pin  <= 1'b1;
      rx_set   <= 1'b0;
      rx_load  <= 1'b0;
      rx_byte  <= 8'h00;
      rx_ninth <= 1'b0;
    end else begin
      rx_set  <= 1'b0;
      rx_load <= 1'b0;
      if (s16_tick) begin
        rx_prev <= rxd_i;
        rx_div  <= rx_div + 4'd1;
      end
      case (rx_st)
        R_IDLE: begin
          rx0_end <= 1'b0;
          if (mode0) begin
            if (rx0_arm && phase == `PH_S6P2) begin
              rx_sr   <= {1'b1, `RX0_PRELOAD};
              rx_st   <= R_M0;
              rx0_arm <= 1'b0;
            end else begin
              // A set still in flight counts: no re-arm after a frame
              rx0_arm <= rx_enable && !rx_done_flag && !rx_set;
            end
          end else if (rx_enable && s16_tick && rx_prev && !rxd_i) begin
            rx_div   <= 4'd0;
            rx_sr    <= `RX_PRELOAD;
            rx_first <= 1'b1;
            rx_st    <= R_BIT;
          end
        end
        R_M0: begin
          if (phase == `PH_S5P2) begin
            rx0_pin <= rxd_i;
          end
          if (rx0_end && phase == `PH_S1P1) begin
            rx_st  <= R_IDLE;
            rx_set <= 1'b1;
          end else if (!rx0_end && phase == `PH_S6P2) begin
            rx_sr[7:0] <= {rx_sr[6:0], rx0_pin};
            if (!rx_sr[7]) begin
              rx0_end <= 1'b1;
              rx_load <= 1'b1;
              rx_byte <= rev8({rx_sr[6:0], rx0_pin});
            end
          end
        end
        R_BIT: begin
          if (s16_tick && rx_div >= `VOTE_FIRST && rx_div <= `VOTE_LAST) begin
            votes <= {rxd_i, votes[2:1]};
          end
          if (rx_roll) begin
            rx_first <= 1'b0;
            if (rx_first && vote) begin
              rx_st <= R_IDLE;
            end else if (!rx_sr[8]) begin
              rx_sr    <= {rx_sr[7:0], vote};
              rx_byte  <= rev8(rx_sr[7:0]);
              rx_ninth <= vote;
              rx_load  <= load_ok;
              rx_set   <= load_ok;
              // Mode 1 final bit is the stop; 2/3 still owe one
              rx_st    <= (mode == 2'd1) ? R_IDLE : R_STOP;
            end else begin
              rx_sr <= {rx_sr[7:0], vote};
            end
          end
        end
        R_STOP: begin
          if (rx_roll) begin
            rx_st <= R_IDLE;
          end
        end
        default: begin
          rx_st <= R_IDLE;
        end
      endcase
    end
  end

  // Frame kept only with flag clear, and multiproc off or address/stop bit set
  assign load_ok = !rx_done_flag && (!multiproc_enable || vote);

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // Shift clock idles high; low from S3P1 to the end of S5
  assign sclk_on = mode0 && ((tx_st == T_DATA) || (rx_st == R_M0));
  assign txd_o   = mode0 ?
                   !(sclk_on && phase >= `PH_S3P1 && phase < `PH_S6P1) :
                   (tx_st == T_START) ? 1'b0 :
                   (tx_st == T_DATA) ? tx_sr[0] : 1'b1;
  // Mode 0 drives data out on the data pin only while sending
  assign rxd_oe_o = mode0 && (tx_st == T_DATA);
  assign rxd_o    = tx_sr[0];

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Hardware sets win over a software write in the same cycle, so a
  // completion landing on a clear is never lost.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_buffer      <= `BUF_RESET;
      mode               <= 2'd0;
      multiproc_enable   <= 1'b0;
      rx_enable          <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      received_ninth_bit <= 1'b0;
      tx_done_flag       <= 1'b0;
      rx_done_flag       <= 1'b0;
      double_rate        <= 1'b0;
      rdata_o            <= 8'h00;
    end else begin
      if (wr_ctl) begin
        mode               <= wdata_i[`CTL_MODE_HI:`CTL_MODE_LO];
        multiproc_enable   <= wdata_i[`CTL_MULTIPROC];
        rx_enable          <= wdata_i[`CTL_RX_ENABLE];
        transmit_ninth_bit <= wdata_i[`CTL_TX_NINTH];
        received_ninth_bit <= wdata_i[`CTL_RX_NINTH];
        tx_done_flag       <= wdata_i[`CTL_TX_DONE];
        rx_done_flag       <= wdata_i[`CTL_RX_DONE];
      end
      if (wr_i && addr_i == `OFS_BAUD_CONTROL) begin
        double_rate <= wdata_i[`BAUD_DOUBLE];
      end
      if (tx_set) begin
        tx_done_flag <= 1'b1;
      end
      if (rx_set) begin
        rx_done_flag <= 1'b1;
      end
      if (rx_load) begin
        serial_buffer <= rx_byte;
        if (!mode0) begin
          received_ninth_bit <= rx_ninth;
        end
      end
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `OFS_SERIAL_BUFFER:  rdata_o <= serial_buffer;
          `OFS_SERIAL_CONTROL: rdata_o <= {mode, multiproc_enable,
                                 rx_enable, transmit_ninth_bit,
                                 received_ninth_bit, tx_done_flag,
                                 rx_done_flag};
          `OFS_BAUD_CONTROL:   rdata_o <= {7'h00, double_rate};
          default:             rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule // serial_port_shift_engine

//--- sim/serial_port_shift_engine_properties.sv
// Port-level assertions for the serial port shift engine
`timescale 1ns/1ps
`include "serial_port_shift_engine_regs.vh"
module serial_port_shift_engine_properties (
  input wire       clk_sys_i,
  input wire       rst_n_i,
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       baud_tick_i,
  input wire       rxd_i,
  input wire       rxd_o,
  input wire       rxd_oe_o,
  input wire       txd_o
);
  reg  [7:0] ctl_q;
  reg        tx_seen;
  reg  [7:0] oe_len;
  wire       wr_buf = wr_i && addr_i == `OFS_SERIAL_BUFFER;
  wire       wr_ctl = wr_i && addr_i == `OFS_SERIAL_CONTROL;
  wire       rd_ctl = rd_i && addr_i == `OFS_SERIAL_CONTROL;

  // Software copy of control, pending send, send window length
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_q   <= `CTL_RESET;
      tx_seen <= 1'b0;
      oe_len  <= 8'h00;
    end else begin
      if (wr_ctl)
        ctl_q <= wdata_i;
      if (wr_buf)
        tx_seen <= 1'b1;
      else if (wr_ctl && !wdata_i[`CTL_TX_DONE])
        tx_seen <= 1'b0;
      oe_len <= rxd_oe_o ? oe_len + 8'h01 : 8'h00;
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_clk_low;
    !txd_o [*6] ##1 txd_o;
  endsequence
  sequence s_send_open;
    ##[12:25] $rose(rxd_oe_o);
  endsequence
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  property p_unmapped;
    rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00;
  endproperty
  property p_ctl_rd;
    rd_ctl |=> rdata_o[7:3] == ctl_q[7:3];
  endproperty
  property p_oe_mode0;
    rxd_oe_o |-> ctl_q[7:6] == 2'b00;
  endproperty
  property p_clk_low;
    $fell(txd_o) && rxd_oe_o |-> s_clk_low;
  endproperty
  property p_clk_high;
    $rose(txd_o) && rxd_oe_o |-> txd_o [*6];
  endproperty
  property p_data_edge;
    rxd_oe_o && $past(rxd_oe_o) && $changed(rxd_o) |-> txd_o && $past(txd_o);
  endproperty
  property p_send_len;
    $fell(rxd_oe_o) |-> oe_len >= 8'd96 && oe_len <= 8'd97;
  endproperty
  property p_tx_flag;
    rd_ctl && !tx_seen |=> !rdata_o[`CTL_TX_DONE];
  endproperty
  property p_send_start;
    wr_buf && ctl_q[7:6] == 2'b00 && !rxd_oe_o |-> s_send_open;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("control readback differs");
  a_oe_mode0: assert property (p_oe_mode0)
    else $error("data pin driven outside mode 0");
  a_clk_low: assert property (p_clk_low)
    else $error("shift clock low phase wrong");
  a_clk_high: assert property (p_clk_high)
    else $error("shift clock high phase short");
  a_data_edge: assert property (p_data_edge)
    else $error("data moved while clock low");
  a_send_len: assert property (p_send_len)
    else $error("send window length wrong");
  a_tx_flag: assert property (p_tx_flag)
    else $error("transmit flag without a send");
  a_send_start: assert property (p_send_start)
    else $error("send did not open in time");
endmodule // serial_port_shift_engine_properties

//--- sim/serial_partner_model.sv
// Far-side serial partner: async frames and a mode 0 shift register
`timescale 1ns/1ps
module serial_partner_model (
  input  wire clk_sys_i,
  input  wire line_i,
  input  wire shift_clk_i,
  output wire line_o
);
  reg       async_lvl;
  reg       src_en;
  reg [7:0] src;
  reg [7:0] cap;
  integer   i;

  // Pull-up: a released line reads high
  assign line_o = src_en ? src[0] : async_lvl;

  // Idle state at time zero
  initial begin
    async_lvl = 1'b1;
    src_en    = 1'b0;
    src       = 8'hff;
    cap       = 8'h00;
  end

  // Capture on the clock rise, then present the next source bit
  always @(posedge shift_clk_i) begin
    cap <= {line_i, cap[7:1]};
    if (src_en)
      src <= {1'b1, src[7:1]};
  end

  task src_set(input en, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      src    <= d;
      src_en <= en;
    end
  endtask

  // A two-clock spike on bit 1 can spoil only one of three samples
  task send_frame(input [10:0] bits, input integer n, input integer bt);
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk_sys_i);
        async_lvl <= bits[i];
        repeat (bt / 2 - 1) @(posedge clk_sys_i);
        if (i == 1)
          async_lvl <= ~bits[i];
        repeat (2) @(posedge clk_sys_i);
        async_lvl <= bits[i];
        repeat (bt / 2 - 2) @(posedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      async_lvl <= 1'b1;
    end
  endtask

  task glitch(input integer n);
    begin
      @(posedge clk_sys_i);
      async_lvl <= 1'b0;
      repeat (n) @(posedge clk_sys_i);
      async_lvl <= 1'b1;
    end
  endtask

  task recv_frame(input integer n, input integer bt, output [10:0] got);
    integer k;
    begin
      got = 11'h000;
      @(negedge shift_clk_i);
      repeat (bt / 2) @(posedge clk_sys_i);
      for (k = 0; k < n; k = k + 1) begin
        got[k] = shift_clk_i;
        repeat (bt) @(posedge clk_sys_i);
      end
    end
  endtask
endmodule // serial_partner_model

//--- sim/serial_port_shift_engine_test.sv
// Self-checking bench for the serial port shift engine
`timescale 1ns/1ps
`include "serial_port_shift_engine_regs.vh"
module serial_port_shift_engine_test;
  localparam integer BT = 32; // Clocks per bit: a tick every 2 clocks
  reg         clk_sys_i;
  reg         rst_n_i;
  reg  [1:0]  addr_i;
  reg  [7:0]  wdata_i;
  reg         wr_i;
  reg         rd_i;
  reg         baud_tick_i;
  wire [7:0]  rdata_o;
  wire        rxd_o;
  wire        rxd_oe_o;
  wire        txd_o;
  wire        line_p;
  wire        rxd_w;
  reg  [7:0]  v, c, d, bufv;
  reg  [10:0] fr;
  reg  [19:0] e;
  reg  [19:0] rx_tab [0:6];
  integer     i;
  integer     err_count;
  integer     n_checks;

  serial_port_shift_engine dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .baud_tick_i(baud_tick_i), .rxd_i(rxd_w), .rxd_o(rxd_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o)
  );
  serial_partner_model pm_u (
    .clk_sys_i(clk_sys_i), .line_i(rxd_w), .shift_clk_i(txd_o),
    .line_o(line_p)
  );

  // Shared data pin: engine wins while it drives
  assign rxd_w = rxd_oe_o ? rxd_o : line_p;

  // 40 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Timer overflow pulse every second clock
  always @(posedge clk_sys_i) baud_tick_i <= ~baud_tick_i;

  // ----------
  // Bus tasks
  // ----------
  task wr(input [1:0] a, input [7:0] dv);
    begin
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= dv;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i    <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, output [7:0] dv);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i   <= 1'b0;
      @(negedge clk_sys_i);
      dv = rdata_o;
    end
  endtask
  task chk(input [10:0] got, input [10:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rd_chk(input [1:0] a, input [7:0] ev);
    begin
      rd(a, v);
      chk({3'b000, v}, {3'b000, ev});
    end
  endtask
  // Poll control under a bound; a flag never set is a mismatch
  task wait_flag(input integer b);
    integer k;
    begin
      v = 8'h00;
      for (k = 0; k < 400 && v[b] !== 1'b1; k = k + 1)
        rd(`OFS_SERIAL_CONTROL, v);
      chk({10'h000, v[b]}, 11'h001);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // Watchdog far beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    err_count = err_count + 1;
    $display("mismatch at %0t: timeout", $time);
    stop_test;
  end

  // ----------
  // Tests
  // ----------
  initial begin
    rst_n_i     = 1'b0;
    addr_i      = 2'h0;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    baud_tick_i = 1'b0;
    err_count   = 0;
    n_checks    = 0;
    bufv        = 8'h3c;
    // Load flag, control, frame {stop (modes 2/3), stop/ninth, data, start}
    rx_tab[0] = {1'b1, 8'h50, 2'b01, 8'h5a, 1'b0};
    rx_tab[1] = {1'b0, 8'h51, 2'b01, 8'h11, 1'b0};
    rx_tab[2] = {1'b0, 8'h70, 2'b00, 8'h22, 1'b0};
    rx_tab[3] = {1'b1, 8'h70, 2'b01, 8'h33, 1'b0};
    rx_tab[4] = {1'b0, 8'hf0, 2'b10, 8'h44, 1'b0};
    rx_tab[5] = {1'b1, 8'hf0, 2'b11, 8'h55, 1'b0};
    rx_tab[6] = {1'b1, 8'h90, 2'b10, 8'h66, 1'b0};
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_chk(`OFS_SERIAL_CONTROL, `CTL_RESET);
    rd_chk(`OFS_SERIAL_BUFFER, `BUF_RESET);
    rd_chk(`OFS_BAUD_CONTROL, `BAUD_RESET);
    wr(2'h3, 8'hff);
    rd_chk(2'h3, 8'h00);
    rd_chk(`OFS_SERIAL_CONTROL, `CTL_RESET);
    wr(`OFS_SERIAL_BUFFER, 8'ha5);
    wait_flag(`CTL_TX_DONE);
    chk({3'b000, pm_u.cap}, 11'h0a5);
    wr(`OFS_SERIAL_CONTROL, 8'h00);
    rd_chk(`OFS_SERIAL_CONTROL, 8'h00);
    pm_u.src_set(1'b1, 8'h3c);
    wr(`OFS_SERIAL_CONTROL, 8'h10);
    wait_flag(`CTL_RX_DONE);
    rd_chk(`OFS_SERIAL_BUFFER, 8'h3c);
    pm_u.src_set(1'b0, 8'hff);
    // Async sends in modes 1, 2, 3, then mode 1 without rate doubling;
    // the control write clears flags
    for (i = 0; i < 4; i = i + 1) begin
      c = (i == 1) ? 8'h88 : (i == 2) ? 8'hc0 : 8'h40;
      d = 8'h96 ^ c ^ i[7:0];
      wr(`OFS_BAUD_CONTROL, (i == 3) ? 8'h00 : 8'h01);
      wr(`OFS_SERIAL_CONTROL, c);
      fork
        pm_u.recv_frame(10 + (c[7:6] != 2'b01), (i == 3) ? 2 * BT : BT, fr);
        wr(`OFS_SERIAL_BUFFER, d);
      join
      chk(fr, (c[7:6] == 2'b01) ? {2'b01, d, 1'b0} :
          {1'b1, c[3], d, 1'b0});
      wait_flag(`CTL_TX_DONE);
    end
    wr(`OFS_BAUD_CONTROL, 8'h01);
    // Receives, each after a false start; some frames must be dropped
    for (i = 0; i < 7; i = i + 1) begin
      e = rx_tab[i];
      wr(`OFS_SERIAL_CONTROL, e[18:11]);
      pm_u.glitch(4);
      repeat (BT) @(posedge clk_sys_i);
      pm_u.send_frame(e[10:0], 11 - (e[18:17] == 2'b01), BT);
      repeat (2 * BT) @(posedge clk_sys_i);
      c = e[18:11];
      if (e[19])
        c[2:0] = {e[9], c[1], 1'b1};
      if (e[19])
        bufv = e[8:1];
      rd_chk(`OFS_SERIAL_CONTROL, c);
      rd_chk(`OFS_SERIAL_BUFFER, bufv);
    end
    stop_test;
  end
endmodule // serial_port_shift_engine_test

bind serial_port_shift_engine serial_port_shift_engine_properties chk_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .baud_tick_i(baud_tick_i), .rxd_i(rxd_i), .rxd_o(rxd_o),
  .rxd_oe_o(rxd_oe_o), .txd_o(txd_o)
);
